/* File: waveform_output_timing_regs.vh */
`ifndef WOT_REGS_VH
`define WOT_REGS_VH
`define WOT_CTRL 8'h00
`define WOT_MODE 8'h04
`define WOT_ROUTE 8'h08
`define WOT_COUNT 8'h0C
`define WOT_PERIOD 8'h10
`define WOT_DELAY 8'h14
`define WOT_DATA 8'h18
`define WOT_STATUS 8'h1C
`define WOT_C_START 0
`define WOT_C_STOP 1
`define WOT_C_UPD 2
`define WOT_C_SWTRIG 3
`define WOT_M_TMODE 1:0
`define WOT_M_CONT 2
`define WOT_M_REGEN 4:3
`define WOT_M_RETRIG 5
`define WOT_M_TRIG_EN 6
`define WOT_M_TRIG_FALL 7
`define WOT_M_TRIG_ANA 8
`define WOT_M_HOLD_EN 9
`define WOT_M_HOLD_LOW 10
`define WOT_M_HOLD_ANA 11
`define WOT_M_TICK_EXT 12
`define WOT_M_TICK_FALL 13
`define WOT_M_CH0 14
`define WOT_M_CH1 15
`define WOT_M_TRIG_SEL 20:16
`define WOT_M_HOLD_SEL 28:24
`define WOT_R_PIN 3:0
`define WOT_R_EN 4
`define WOT_S_UFL 1
`define WOT_S_LATE 2
`define WOT_TM_SW 2'h0
`define WOT_TM_TSP 2'h1
`define WOT_TM_BUF 2'h2
`define WOT_RG_HOST 2'h0
`define WOT_RG_FIFO 2'h1
`define WOT_RG_NONE 2'h2
`define WOT_MODE_RST 32'h0000C000
`define WOT_COUNT_RST 32'h00000004
`define WOT_PERIOD_RST 32'h00000064
`define WOT_DELAY_RST 32'h00000002
`define WOT_FIFO_DEPTH 5'h10
`define WOT_FIFO_NEARLY 5'h0F
`endif

/* File: wot_top.v */
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "waveform_output_timing_regs.vh"
// Function
// - Software update command makes one DAC conversion.
// - Timed single point flags a late sample.
// - Buffered mode feeds FIFO samples per tick.
// - Finite mode stops after programmed sample count.
// - Continuous mode runs until stop command.
// - Host regeneration repeats data, default setting.
// - Local FIFO replay loops, refuses new writes.
// - Non-regeneration flags underflow on missing sample.
// - Without trigger, software start begins generation.
// - Retriggerable: full tick sequence per trigger.
// - Triggers ignored while a sequence runs.
// - After retriggered sequence, rearm for trigger.
// - Digital launch trigger edge is selectable.
// - Analog launch uses comparator rising edge.
// - Routed launch pulse active high; pins input.
// - Launch selector covers software, pins, buses, events.
// - Active hold trigger suppresses all tick updates; software update commands still act.
// - Hold acts from the next sample boundary.
// - Internal tick resumes at once after hold.
// - External tick resumes on next edge.
// - Digital hold polarity selectable, level sensitive.
// - Analog hold suppresses while comparator high.
// - Each tick updates enabled channels, edge selectable.
// - Configurable launch-to-first-tick delay, default two.
module wot_top (
  // Clock and reset.
  input wire clock,
  input wire reset_n,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // DMA sample stream.
  input wire dma_valid,
  input wire [31:0] dma_data,
  output reg dma_ready_r,
  // Trigger and tick sources.
  input wire [15:0] function_pin_in,
  input wire [7:0] sync_bus_line_in,
  input wire counter_out_in,
  input wire change_detect_in,
  input wire other_trigger_in,
  input wire analog_cmp_in,
  input wire ext_tick_in,
  // Function pin drive.
  output reg [15:0] function_pin_out_r,
  output reg [15:0] function_pin_oe_n_r,
  // DAC side.
  output reg [15:0] dac0_data_r,
  output reg [15:0] dac1_data_r,
  output reg output_update_tick_r,
  output reg running_r
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_ARM = 4'b0010;
  localparam ST_DLY = 4'b0100;
  localparam ST_RUN = 4'b1000;
  reg [31:0] mode_r, route_r, count_r, period_r, delay_r, sw_sample_r;
  reg [28:0] s1_r, s2_r;
  reg swtrig_r, trig_prev_r, cmp_prev_r, tick_prev_r;
  reg [3:0] st_r;
  reg [31:0] cnt_r, dly_r, div_r;
  reg ufl_r, late_r, fresh_r, launch_r;
  reg [31:0] mem [0:15];
  reg [3:0] wp_r, rp_r, ofs_r;
  reg [4:0] lvl_r;
  reg [31:0] rdata_nxt;
  reg hit_nxt;
  wire [28:0] raw_in = {ext_tick_in, analog_cmp_in, other_trigger_in, change_detect_in, counter_out_in,
                        sync_bus_line_in, function_pin_in};
  // Each outside level passes two flip-flops before use.
  genvar g;
  generate
    for (g = 0; g < 29; g = g + 1) begin : g_sync
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= raw_in[g];
          s2_r[g] <= s1_r[g];
        end
      end
    end
  endgenerate
  wire wr_en = psel & penable & pready & pwrite;
  wire start_p = wr_en & (paddr == `WOT_CTRL) & pwdata[`WOT_C_START];
  wire stop_p = wr_en & (paddr == `WOT_CTRL) & pwdata[`WOT_C_STOP];
  wire upd_p = wr_en & (paddr == `WOT_CTRL) & pwdata[`WOT_C_UPD];
  wire pio_wr = wr_en & (paddr == `WOT_DATA);
  wire stat_wr = wr_en & (paddr == `WOT_STATUS);
  wire [1:0] tmode = mode_r[`WOT_M_TMODE];
  wire [1:0] regen = mode_r[`WOT_M_REGEN];
  wire buf_mode = (tmode == `WOT_TM_BUF);
  wire rg_fifo = (regen == `WOT_RG_FIFO);
  // Selectable sources: software pulse, pins, sync lines, counter, change, other.
  wire [31:0] srcv = {4'h0, s2_r[26:0], swtrig_r};
  wire trig_lvl = srcv[mode_r[`WOT_M_TRIG_SEL]];
  wire dig_edge = mode_r[`WOT_M_TRIG_FALL] ? (trig_prev_r & ~trig_lvl) : (~trig_prev_r & trig_lvl);
  wire ana_edge = ~cmp_prev_r & s2_r[27];
  wire trig_hit = mode_r[`WOT_M_TRIG_ANA] ? ana_edge : dig_edge;
  wire hold_lvl = srcv[mode_r[`WOT_M_HOLD_SEL]] ^ mode_r[`WOT_M_HOLD_LOW];
  wire hold_act = mode_r[`WOT_M_HOLD_EN] & (mode_r[`WOT_M_HOLD_ANA] ? s2_r[27] : hold_lvl);
  wire ext_edge = mode_r[`WOT_M_TICK_FALL] ? (tick_prev_r & ~s2_r[28]) : (~tick_prev_r & s2_r[28]);
  wire tick_src = mode_r[`WOT_M_TICK_EXT] ? ext_edge : (div_r == 32'h0);
  // An update is a single cycle, so gating the tick never cuts one short.
  wire tick = (st_r == ST_RUN) & tick_src & ~hold_act;
  wire refuse = buf_mode & rg_fifo & (st_r != ST_IDLE);
  wire dma_acc = dma_valid & dma_ready_r;
  wire push = (dma_acc | (pio_wr & buf_mode)) & ~refuse & (lvl_r != `WOT_FIFO_DEPTH);
  wire [31:0] push_data = dma_acc ? dma_data : pwdata;
  wire avail = (lvl_r != 5'h00);
  wire do_buf = tick & buf_mode;
  wire pop = do_buf & avail & ~rg_fifo;
  wire [3:0] rd_idx = rp_r + ofs_r;
  wire [31:0] head = mem[rd_idx];
  wire [3:0] ofs_inc = ofs_r + 4'h1;
  wire upd_hw = tick & (tmode != `WOT_TM_SW);
  wire [31:0] cnt_inc = cnt_r + 32'h1;
  wire [31:0] dly_inc = dly_r + 32'h1;
  wire last = ~mode_r[`WOT_M_CONT] & (cnt_inc >= count_r);
  wire rearm = mode_r[`WOT_M_RETRIG] & mode_r[`WOT_M_TRIG_EN];
  wire [31:0] status_w = {26'h0, (st_r == ST_ARM), ~avail, (lvl_r == `WOT_FIFO_DEPTH), late_r, ufl_r, running_r};
  always @* begin
    rdata_nxt = 32'h0;
    hit_nxt = 1'b1;
    if (paddr == `WOT_CTRL) begin
      rdata_nxt = 32'h0;
    end else if (paddr == `WOT_MODE) begin
      rdata_nxt = mode_r;
    end else if (paddr == `WOT_ROUTE) begin
      rdata_nxt = {27'h0, route_r[4:0]};
    end else if (paddr == `WOT_COUNT) begin
      rdata_nxt = count_r;
    end else if (paddr == `WOT_PERIOD) begin
      rdata_nxt = period_r;
    end else if (paddr == `WOT_DELAY) begin
      rdata_nxt = delay_r;
    end else if (paddr == `WOT_DATA) begin
      rdata_nxt = sw_sample_r;
    end else if (paddr == `WOT_STATUS) begin
      rdata_nxt = status_w;
    end else begin
      hit_nxt = 1'b0;
    end
  end
  // Bus slave with one wait state; writes act at the completing edge.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      mode_r <= `WOT_MODE_RST;
      route_r <= 32'h0;
      count_r <= `WOT_COUNT_RST;
      period_r <= `WOT_PERIOD_RST;
      delay_r <= `WOT_DELAY_RST;
      sw_sample_r <= 32'h0;
      swtrig_r <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h0 : rdata_nxt;
        pslverr <= ~hit_nxt;
      end
      swtrig_r <= wr_en & (paddr == `WOT_CTRL) & pwdata[`WOT_C_SWTRIG];
      if (wr_en) begin
        if (paddr == `WOT_MODE) begin
          mode_r <= pwdata;
        end else if (paddr == `WOT_ROUTE) begin
          route_r <= pwdata;
        end else if (paddr == `WOT_COUNT) begin
          count_r <= pwdata;
        end else if (paddr == `WOT_PERIOD) begin
          period_r <= pwdata;
        end else if (paddr == `WOT_DELAY) begin
          delay_r <= pwdata;
        end else if ((paddr == `WOT_DATA) & ~buf_mode) begin
          sw_sample_r <= pwdata;
        end
      end
    end
  end
  // Timing engine: idle, armed, start delay, running.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 32'h0;
      dly_r <= 32'h0;
      div_r <= 32'h0;
      launch_r <= 1'b0;
      running_r <= 1'b0;
      trig_prev_r <= 1'b0;
      cmp_prev_r <= 1'b0;
      tick_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_lvl;
      cmp_prev_r <= s2_r[27];
      tick_prev_r <= s2_r[28];
      launch_r <= (st_r == ST_ARM) & trig_hit & ~stop_p;
      if (stop_p) begin
        st_r <= ST_IDLE;
        running_r <= 1'b0;
      end else begin
        case (st_r)
          ST_IDLE: begin
            if (start_p) begin
              st_r <= mode_r[`WOT_M_TRIG_EN] ? ST_ARM : ST_DLY;
              running_r <= 1'b1;
              cnt_r <= 32'h0;
              dly_r <= 32'h0;
            end
          end
          ST_ARM: begin
            if (trig_hit) begin
              st_r <= ST_DLY;
              dly_r <= 32'h0;
              cnt_r <= 32'h0;
            end
          end
          ST_DLY: begin
            dly_r <= dly_inc;
            if (dly_inc >= delay_r) begin
              st_r <= ST_RUN;
              div_r <= 32'h0;
            end
          end
          ST_RUN: begin
            if (~mode_r[`WOT_M_TICK_EXT] & ~hold_act) begin
              div_r <= (div_r == 32'h0) ? (period_r - 32'h1) : (div_r - 32'h1);
            end
            if (period_r == 32'h0) begin
              div_r <= 32'h0;
            end
            if (upd_hw) begin
              cnt_r <= cnt_inc;
              if (last) begin
                st_r <= rearm ? ST_ARM : ST_IDLE;
                running_r <= rearm;
                cnt_r <= 32'h0;
              end
            end
          end
          default: begin
            st_r <= ST_IDLE;
            running_r <= 1'b0;
          end
        endcase
      end
    end
  end
  // Sample FIFO storage.
  always @(posedge clock) begin
    if (push) begin
      mem[wp_r] <= push_data;
    end
  end
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= 4'h0;
      rp_r <= 4'h0;
      ofs_r <= 4'h0;
      lvl_r <= 5'h00;
      dma_ready_r <= 1'b0;
    end else begin
      dma_ready_r <= ~refuse & (lvl_r < `WOT_FIFO_NEARLY);
      if (push) begin
        wp_r <= wp_r + 4'h1;
      end
      if (pop) begin
        rp_r <= rp_r + 4'h1;
      end
      if (push & ~pop) begin
        lvl_r <= lvl_r + 5'h01;
      end else if (pop & ~push) begin
        lvl_r <= lvl_r - 5'h01;
      end
      if (st_r == ST_IDLE) begin
        ofs_r <= 4'h0;
      end else if (do_buf & avail & rg_fifo) begin
        ofs_r <= ({1'b0, ofs_inc} == lvl_r) ? 4'h0 : ofs_inc;
      end
    end
  end
  // DAC updates and sticky error flags.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dac0_data_r <= 16'h0000;
      dac1_data_r <= 16'h0000;
      output_update_tick_r <= 1'b0;
      ufl_r <= 1'b0;
      late_r <= 1'b0;
      fresh_r <= 1'b0;
    end else begin
      output_update_tick_r <= (upd_p & (tmode == `WOT_TM_SW)) | upd_hw;
      if ((upd_p & (tmode == `WOT_TM_SW)) | (tick & (tmode == `WOT_TM_TSP))) begin
        if (mode_r[`WOT_M_CH0]) begin
          dac0_data_r <= sw_sample_r[15:0];
        end
        if (mode_r[`WOT_M_CH1]) begin
          dac1_data_r <= sw_sample_r[31:16];
        end
      end else if (do_buf & avail) begin
        if (mode_r[`WOT_M_CH0]) begin
          dac0_data_r <= head[15:0];
        end
        if (mode_r[`WOT_M_CH1]) begin
          dac1_data_r <= head[31:16];
        end
      end
      if (tick & (tmode == `WOT_TM_TSP)) begin
        fresh_r <= 1'b0;
      end
      if (pio_wr & ~buf_mode) begin
        fresh_r <= 1'b1;
      end
      if (stat_wr & pwdata[`WOT_S_UFL]) begin
        ufl_r <= 1'b0;
      end
      if (do_buf & ~avail & (regen != `WOT_RG_HOST)) begin
        ufl_r <= 1'b1;
      end
      if (stat_wr & pwdata[`WOT_S_LATE]) begin
        late_r <= 1'b0;
      end
      if (tick & (tmode == `WOT_TM_TSP) & ~fresh_r & ~pio_wr) begin
        late_r <= 1'b1;
      end
    end
  end
  // Launch pulse routed to one function pin; others stay inputs.
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_pin
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          function_pin_out_r[g] <= 1'b0;
          function_pin_oe_n_r[g] <= 1'b1;
        end else begin
          function_pin_oe_n_r[g] <= ~(route_r[`WOT_R_EN] & (route_r[`WOT_R_PIN] == g));
          function_pin_out_r[g] <= route_r[`WOT_R_EN] & (route_r[`WOT_R_PIN] == g) & launch_r;
        end
      end
    end
  endgenerate
endmodule // wot_top

/* File: wot_monitor.sv */
`timescale 1ns/1ns
`include "waveform_output_timing_regs.vh"
module wot_monitor (
  // Clock and reset.
  input logic clock,
  input logic reset_n,
  // APB.
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Hold sources.
  input logic [7:0] sync_bus_line_in,
  input logic analog_cmp_in,
  // Outputs.
  input logic dma_ready_r,
  input logic [15:0] function_pin_out_r,
  input logic [15:0] function_pin_oe_n_r,
  input logic output_update_tick_r,
  input logic running_r
);
  logic [31:0] mode_r;
  logic [5:0] held_r;
  wire wr = psel && penable && pready && pwrite;
  wire ctl = wr && paddr == `WOT_CTRL;
  wire [4:0] hs = mode_r[28:24] - 5'h11;
  wire hold = mode_r[9] && (mode_r[11] ? analog_cmp_in : hs < 5'h8 && (sync_bus_line_in[hs[2:0]] ^ mode_r[10]));
  // Shadows the mode register and ages the hold level.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= `WOT_MODE_RST;
      held_r <= 6'h0;
    end else begin
      if (wr && paddr == `WOT_MODE) begin
        mode_r <= pwdata;
      end
      held_r <= {held_r[4:0], hold};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late answer");
  a_bad_addr: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused data");
  a_pins_input: assert property ($rose(reset_n) |-> function_pin_oe_n_r == 16'hFFFF)
    else $error("pins not inputs");
  a_pulse_once: assert property (|function_pin_out_r |=> function_pin_out_r == 16'h0)
    else $error("launch pulse too long");
  a_start_runs: assert property (ctl && pwdata[0] && !pwdata[1] && !mode_r[6] |-> ##[1:2] running_r)
    else $error("start ignored");
  a_stop_idle: assert property (ctl && pwdata[1] |-> ##[1:2] !running_r)
    else $error("stop ignored");
  a_hold_mutes: assert property (&held_r && hold |-> !output_update_tick_r)
    else $error("tick while held");
  a_replay_refuse: assert property (
    mode_r[4:3] == `WOT_RG_FIFO && running_r && $past(running_r) && $past(running_r, 2) |-> !dma_ready_r)
    else $error("replay accepts data");
endmodule // wot_monitor

/* File: wot_dma_host.sv */
`timescale 1ns/1ns
module wot_dma_host (
  // Clock and reset.
  input logic clock,
  input logic reset_n,
  // Beats to offer in total.
  input logic [7:0] n_beats,
  // Stream.
  input logic dma_ready_r,
  output logic dma_valid,
  output logic [31:0] dma_data,
  output logic [7:0] sent
);
  wire take = dma_valid && dma_ready_r;
  wire [7:0] nx = sent + {7'h0, take};
  wire [15:0] smp = 16'h5000 + {8'h0, nx};
  // An idle stream inverts its data word every cycle.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dma_valid <= 1'h0;
      dma_data <= 32'h0;
      sent <= 8'h0;
    end else begin
      sent <= nx;
      dma_valid <= nx < n_beats;
      dma_data <= nx < n_beats ? {~smp, smp} : ~dma_data;
    end
  end
endmodule // wot_dma_host

/* File: waveform_output_timing_tb.sv */
`timescale 1ns/1ns
`include "waveform_output_timing_regs.vh"
module waveform_output_timing_tb;
  logic clock = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, analog_cmp_in = 1'h0;
  logic [7:0] paddr = 8'h0, n_beats = 8'h0, sync_bus_line_in = 8'hFF, sent;
  logic [31:0] pwdata = 32'h0, rd, prdata, dma_data;
  logic [15:0] function_pin_in = 16'hFFFF, function_pin_out_r, function_pin_oe_n_r, dac0_data_r, dac1_data_r;
  logic pready, pslverr, er, dma_valid, dma_ready_r, output_update_tick_r, running_r;
  logic ext_tick_in = 1'h0;
  int mismatches = 0, n_checks = 0, ticks = 0, pulses = 0, cyc = 0, t0, p0;
  wot_top dut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dma_valid,
    .dma_data, .dma_ready_r, .function_pin_in, .sync_bus_line_in, .counter_out_in(1'h0), .change_detect_in(1'h0),
    .other_trigger_in(1'h0), .analog_cmp_in, .ext_tick_in, .function_pin_out_r, .function_pin_oe_n_r,
    .dac0_data_r, .dac1_data_r, .output_update_tick_r, .running_r);
  wot_dma_host host (.clock, .reset_n, .n_beats, .dma_ready_r, .dma_valid, .dma_data, .sent);
  initial forever #4 clock = ~clock;
  // Counts update ticks, launch pulses and cycles.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (output_update_tick_r === 1'h1) ticks <= ticks + 1;
    if (function_pin_out_r[5] === 1'h1) pulses <= pulses + 1;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task go(input logic [31:0] m, c, p);
    apb(1'h1, `WOT_MODE, m);
    apb(1'h1, `WOT_COUNT, c);
    apb(1'h1, `WOT_PERIOD, p);
    apb(1'h1, `WOT_CTRL, 32'h1);
  endtask
  task idle;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 500 && running_r !== 1'h0; i++) @(posedge clock);
    repeat (2) @(posedge clock);
  endtask
  task t_sw;
    apb(1'h1, `WOT_DATA, 32'h1234ABCD);
    apb(1'h1, `WOT_CTRL, 32'h4);
    repeat (8) @(posedge clock);
    chk("sw dac", 32'h1234ABCD, {dac1_data_r, dac0_data_r});
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'h0, `WOT_DELAY, 32'h0);
    chk("delay reset", `WOT_DELAY_RST, rd);
  endtask
  task t_ext;
    apb(1'h1, `WOT_DELAY, 32'h5);
    go(32'h0000D141, 32'h2, 32'h1);
    apb(1'h1, `WOT_DATA, 32'h5A5AA5A5);
    t0 = ticks;
    p0 = pulses;
    analog_cmp_in <= 1'h1;
    repeat (12) @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      ext_tick_in <= 1'h1;
      repeat (4) @(posedge clock);
      ext_tick_in <= 1'h0;
      repeat (4) @(posedge clock);
    end
    analog_cmp_in <= 1'h0;
    chk("ext ticks", 32'h2, ticks - t0);
    chk("analog launch", 32'h1, pulses - p0);
    chk("ext end", 32'h0, {31'h0, running_r});
    chk("tsp dac", 32'h5A5AA5A5, {dac1_data_r, dac0_data_r});
  endtask
  task t_ufl;
    go(32'h0000C012, 32'h2, 32'h1);
    idle;
    chk("finite end", 32'h0, {31'h0, running_r});
    apb(1'h0, `WOT_STATUS, 32'h0);
    chk("underflow", 32'h1, {31'h0, rd[`WOT_S_UFL]});
    apb(1'h1, `WOT_STATUS, 32'h2);
    apb(1'h0, `WOT_STATUS, 32'h0);
    chk("underflow clr", 32'h0, {31'h0, rd[`WOT_S_UFL]});
  endtask
  task t_late;
    go(32'h0000C005, 32'h4, 32'h10);
    repeat (100) @(posedge clock);
    chk("continuous", 32'h1, {31'h0, running_r});
    apb(1'h1, `WOT_CTRL, 32'h2);
    apb(1'h0, `WOT_STATUS, 32'h0);
    chk("stopped", 32'h0, {31'h0, running_r});
    chk("late", 32'h1, {31'h0, rd[`WOT_S_LATE]});
  endtask
  task t_replay;
    n_beats <= 8'h3;
    for (int i = 0; i < 50 && sent !== 8'h3; i++) @(posedge clock);
    t0 = ticks;
    go(32'h0000C00A, 32'h5, 32'h1);
    idle;
    chk("replay ticks", 32'h5, ticks - t0);
    chk("replay dac", 32'hAFFE5001, {dac1_data_r, dac0_data_r});
  endtask
  task t_trig;
    apb(1'h1, `WOT_ROUTE, 32'h15);
    go(32'h0004C0E2, 32'h2, 32'h8);
    for (int i = 0; i < 2; i++) begin
      t0 = ticks;
      p0 = pulses;
      function_pin_in[3] <= 1'h0;
      repeat (6) @(posedge clock);
      function_pin_in[3] <= 1'h1;
      @(posedge clock);
      function_pin_in[3] <= 1'h0;
      repeat (40) @(posedge clock);
      function_pin_in[3] <= 1'h1;
      repeat (8) @(posedge clock);
      chk("launch ticks", 32'h2, ticks - t0);
      chk("launch pulse", 32'h1, pulses - p0);
    end
    apb(1'h1, `WOT_CTRL, 32'h2);
  endtask
  task t_hold;
    go(32'h1300C606, 32'h4, 32'h1);
    repeat (10) @(posedge clock);
    sync_bus_line_in[2] <= 1'h0;
    repeat (6) @(posedge clock);
    t0 = ticks;
    repeat (20) @(posedge clock);
    chk("held", 32'h0, ticks - t0);
    sync_bus_line_in[2] <= 1'h1;
    repeat (6) @(posedge clock);
    t0 = ticks;
    repeat (10) @(posedge clock);
    chk("resumed", 32'hA, ticks - t0);
    apb(1'h1, `WOT_CTRL, 32'h2);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'h1;
    t_sw;
    t_ufl;
    t_late;
    t_replay;
    t_trig;
    t_hold;
    t_ext;
    tally_and_finish;
  end
endmodule // waveform_output_timing_tb
bind wot_top wot_monitor mon (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .sync_bus_line_in, .analog_cmp_in, .dma_ready_r, .function_pin_out_r, .function_pin_oe_n_r, .output_update_tick_r,
  .running_r);
